// ==== src/mad_decode.sv ====
/*
 Memory-space selection and addressing-mode cost decoder for the core.
 Assumes requests come from core logic on the same clock; one request per
 valid cycle, answer registered one cycle later.
*/
//Function
//(RULE_01) Bit addresses 00-7F map to RAM bytes 20h-2Fh, eight bits each.
//(RULE_02) Special registers sit at 80h-FFh, reachable only by direct addressing.
//(RULE_03) Direct below 80h selects RAM; direct 80h-FFh selects special register.
//(RULE_04) Indirect access to 80h-FFh selects upper internal RAM, never special registers.
//(RULE_05) Only flagged special registers accept single-bit access.
//(RULE_06) Extended RAM is 256 bytes at 0000h-00FFh, via extended moves only.
//(RULE_07) Extended RAM enabled only when configuration bits [1:0] equal 01.
//(RULE_08) No external memory; extended and code accesses stay on chip.
//(RULE_09) Code space is 16 kbyte flash, read only by code moves.
//(RULE_10) Code address is accumulator plus pointer or PC; reads 4, jump 3 cycles.
//(RULE_11) Extended direct uses the data pointer pair; 1 byte, 4 cycles.
//(RULE_12) Extended indirect uses an 8-bit index register; 1 byte, 4 cycles.
//(RULE_13) Immediate 2/2, pointer immediate 3/3, direct 2/2, register 1/1, indirect 1/2.
//(RULE_14) Register-to-register operation is the cheapest mode.
//(RULE_15) Most instructions take one or two cycles.
//(RULE_16) Add register 1 byte 1 cycle; add indirect 1 byte 2 cycles.
//(RULE_17) Stack pointer addresses extended RAM, apart from data RAM.
//(RULE_18) Data pointer extended moves use only the low eight address bits.
`timescale 1ns/1ps
`include "mad_consts.svh"
module mad_decode
	import mad_pkg::*;
#(
	parameter int CODE_ADDR_W = `MAD_CODE_ADDR_W
) (
	input  wire logic                   clock,
	input  wire logic                   nrst,
	input  wire logic                   req_valid,
	input  wire mad_mode_t              req_mode,
	input  wire logic [7:0]             operand,
	input  wire logic [7:0]             index_register,
	input  wire logic [15:0]            data_pointer_pair,
	input  wire logic [15:0]            program_counter,
	input  wire logic [7:0]             accumulator,
	input  wire logic [7:0]             stack_pointer,
	input  wire logic                   stack_access,
	input  wire logic                   sfr_wr,
	input  wire logic [7:0]             sfr_wdata,
	input  wire logic [255:0]           sfr_bit_capable,
	output logic                        ans_valid,
	output mad_space_t                  ans_space,
	output logic [7:0]                  ans_addr,
	output logic [2:0]                  ans_bit,
	output logic [CODE_ADDR_W-1:0]      ans_code_addr,
	output logic [1:0]                  ans_bytes,
	output logic [3:0]                  ans_cycles,
	output logic                        ans_fault,
	output logic [7:0]                  memory_configuration
);
	logic [7:0]             memcfg_reg;
	logic                   valid_reg;
	mad_space_t             space_reg;
	mad_space_t             space_next;
	logic [7:0]             addr_reg;
	logic [7:0]             addr_next;
	logic [2:0]             bit_reg;
	logic [2:0]             bit_next;
	logic [CODE_ADDR_W-1:0] code_reg;
	logic [CODE_ADDR_W-1:0] code_next;
	logic [1:0]             bytes_reg;
	logic [1:0]             bytes_next;
	logic [3:0]             cycles_reg;
	logic [3:0]             cycles_next;
	logic                   fault_reg;
	logic                   fault_next;
	logic                   extended_ram_en;

	// Flash index arithmetic shared by the three code-indirect forms
	function automatic logic [CODE_ADDR_W-1:0] code_index(input logic [15:0] base, input logic [7:0] acc);
		logic [15:0] sum;
		sum = base + {8'h00, acc};
		return sum[CODE_ADDR_W-1:0];
	endfunction

	// Whole byte is kept for read-back; only the two low bits gate the extended RAM
	assign extended_ram_en = (memcfg_reg[`MAD_MEMCFG_EN_MSB:`MAD_MEMCFG_EN_LSB] == `MAD_MEMCFG_EN_VAL); // RULE_07

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			memcfg_reg <= `MAD_MEMCFG_RESET;
		end else if (sfr_wr) begin
			memcfg_reg <= sfr_wdata; // RULE_07
		end
	end

	always_comb begin
		space_next  = MAD_SPACE_NONE;
		addr_next   = operand;
		bit_next    = 3'h0;
		code_next   = '0;
		bytes_next  = `MAD_LEN_ONE;
		cycles_next = `MAD_CYC_REG;
		fault_next  = 1'b0;
		case (req_mode)
			MAD_MODE_REG: begin
				space_next  = MAD_SPACE_IRAM;
				bytes_next  = `MAD_LEN_ONE; // RULE_16
				cycles_next = `MAD_CYC_REG; // RULE_14
			end
			MAD_MODE_DIRECT: begin
				// Only direct and bit addressing reach the special registers
				space_next  = (operand < `MAD_SFR_BASE) ? MAD_SPACE_IRAM : MAD_SPACE_SFR; // RULE_03 RULE_02
				bytes_next  = `MAD_LEN_TWO; // RULE_13
				cycles_next = `MAD_CYC_DIRECT; // RULE_13
			end
			MAD_MODE_INDIRECT: begin
				addr_next   = index_register;
				space_next  = MAD_SPACE_IRAM; // RULE_04 RULE_02
				bytes_next  = `MAD_LEN_ONE; // RULE_16
				cycles_next = `MAD_CYC_INDIRECT; // RULE_13
			end
			MAD_MODE_IMM: begin
				bytes_next  = `MAD_LEN_TWO; // RULE_13
				cycles_next = `MAD_CYC_IMM;
			end
			MAD_MODE_IMM_DATA_POINTER_PAIR: begin
				bytes_next  = `MAD_LEN_THREE; // RULE_13
				cycles_next = `MAD_CYC_IMM_DATA_POINTER_PAIR;
			end
			MAD_MODE_BIT: begin
				bytes_next  = `MAD_LEN_TWO; // RULE_15
				cycles_next = `MAD_CYC_DIRECT;
				bit_next    = operand[2:0];
				if (operand <= `MAD_BIT_ADDR_LAST) begin
					space_next = MAD_SPACE_IRAM;
					addr_next  = `MAD_BIT_RAM_BASE + {3'h0, operand[6:3]}; // RULE_01
				end else if (sfr_bit_capable[{operand[7:3], 3'h0}]) begin
					space_next = MAD_SPACE_SFR;
					addr_next  = {operand[7:3], 3'h0}; // RULE_05
				end else begin
					fault_next = 1'b1; // RULE_05
				end
			end
			MAD_MODE_XDIRECT, MAD_MODE_XINDIRECT: begin
				bytes_next  = `MAD_LEN_ONE;
				cycles_next = `MAD_CYC_XMOVE; // RULE_11 RULE_12
				if (stack_access) begin
					addr_next = stack_pointer; // RULE_17
				end else if (req_mode == MAD_MODE_XDIRECT) begin
					addr_next = data_pointer_pair[7:0]; // RULE_18 RULE_11
				end else begin
					addr_next = index_register; // RULE_12
				end
				// Disabled extended RAM faults rather than going off chip
				if (extended_ram_en) begin
					space_next = MAD_SPACE_EXTENDED_RAM; // RULE_06 RULE_08
				end else begin
					fault_next = 1'b1; // RULE_07
				end
			end
			MAD_MODE_CODE_DATA_POINTER_PAIR, MAD_MODE_CODE_PC: begin
				space_next  = MAD_SPACE_CODE; // RULE_09 RULE_08
				code_next   = code_index((req_mode == MAD_MODE_CODE_PC) ? program_counter : data_pointer_pair,
					accumulator); // RULE_10
				cycles_next = `MAD_CYC_CODE_READ; // RULE_10
			end
			MAD_MODE_JUMP_DATA_POINTER_PAIR: begin
				code_next   = code_index(data_pointer_pair, accumulator); // RULE_10
				cycles_next = `MAD_CYC_CODE_JUMP; // RULE_10
			end
			default: begin
				fault_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			valid_reg  <= 1'b0;
			space_reg  <= MAD_SPACE_NONE;
			addr_reg   <= 8'h00;
			bit_reg    <= 3'h0;
			code_reg   <= '0;
			bytes_reg  <= 2'h0;
			cycles_reg <= 4'h0;
			fault_reg  <= 1'b0;
		end else begin
			valid_reg  <= req_valid;
			space_reg  <= space_next;
			addr_reg   <= addr_next;
			bit_reg    <= bit_next;
			code_reg   <= code_next;
			bytes_reg  <= bytes_next;
			cycles_reg <= cycles_next;
			fault_reg  <= fault_next;
		end
	end

	assign ans_valid            = valid_reg;
	assign ans_space            = space_reg;
	assign ans_addr             = addr_reg;
	assign ans_bit              = bit_reg;
	assign ans_code_addr        = code_reg;
	assign ans_bytes            = bytes_reg;
	assign ans_cycles           = cycles_reg;
	assign ans_fault            = fault_reg;
	assign memory_configuration = memcfg_reg;

	sequence s_indirect_req;
		req_valid && req_mode == MAD_MODE_INDIRECT;
	endsequence

	sequence s_extended_ram_req;
		req_valid && (req_mode == MAD_MODE_XDIRECT || req_mode == MAD_MODE_XINDIRECT);
	endsequence

	sequence s_bit_sfr_req;
		req_valid && req_mode == MAD_MODE_BIT && operand[7];
	endsequence

	AST_BIT_MAP: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
		req_valid && req_mode == MAD_MODE_BIT && operand <= 8'h7F |=> ans_space == MAD_SPACE_IRAM
		&& ans_addr == 8'h20 + {3'h0, $past(operand[6:3])} && ans_bit == $past(operand[2:0]))
		else $error("bit address mapped wrongly");
	AST_INDIRECT_RAM: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
		s_indirect_req |=> ans_space == MAD_SPACE_IRAM && ans_addr == $past(index_register) && ans_cycles == 4'h2)
		else $error("indirect access left internal RAM");
	AST_DIRECT_SPLIT: assert property (@(posedge clock) disable iff (!nrst) // RULE_03
		req_valid && req_mode == MAD_MODE_DIRECT |=>
		ans_space == ($past(operand[7]) ? MAD_SPACE_SFR : MAD_SPACE_IRAM) && ans_bytes == 2'h2)
		else $error("direct space split wrong");
	AST_SFR_DIRECT_ONLY: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
		ans_valid && ans_space == MAD_SPACE_SFR |-> $past(req_mode) inside {MAD_MODE_DIRECT, MAD_MODE_BIT})
		else $error("special register reached other than directly");
	AST_EXTENDED_RAM_GATE: assert property (@(posedge clock) disable iff (!nrst) // RULE_07
		req_valid && req_mode == MAD_MODE_XINDIRECT && memory_configuration[1:0] != 2'h1 |=> ans_fault)
		else $error("extended RAM used while disabled");
	AST_XDIRECT_LOW: assert property (@(posedge clock) disable iff (!nrst) // RULE_18
		req_valid && req_mode == MAD_MODE_XDIRECT && !stack_access |=>
		ans_addr == $past(data_pointer_pair[7:0]) && ans_cycles == 4'h4)
		else $error("extended direct address wrong");
	AST_CODE_READ: assert property (@(posedge clock) disable iff (!nrst) // RULE_10
		req_valid && req_mode == MAD_MODE_CODE_PC |=> ans_space == MAD_SPACE_CODE && ans_cycles == 4'h4
		&& ans_code_addr == 14'($past(program_counter) + {8'h00, $past(accumulator)}))
		else $error("code read wrong");
	AST_JUMP: assert property (@(posedge clock) disable iff (!nrst) // RULE_10
		req_valid && req_mode == MAD_MODE_JUMP_DATA_POINTER_PAIR |=> ans_cycles == 4'h3)
		else $error("indexed jump cost wrong");
	AST_REG_CHEAPEST: assert property (@(posedge clock) disable iff (!nrst) // RULE_14
		req_valid && req_mode == MAD_MODE_REG |=> ans_cycles == 4'h1 && ans_bytes == 2'h1)
		else $error("register mode not cheapest");
	AST_IMM_DATA_POINTER_PAIR: assert property (@(posedge clock) disable iff (!nrst) // RULE_13
		req_valid && req_mode == MAD_MODE_IMM_DATA_POINTER_PAIR |=> ans_bytes == 2'h3 && ans_cycles == 4'h3)
		else $error("pointer immediate cost wrong");
	AST_CFG_WRITE: assert property (@(posedge clock) disable iff (!nrst) // RULE_07
		sfr_wr |=> memory_configuration == $past(sfr_wdata))
		else $error("configuration write lost");
	// A reset in mid-flight aborts pending attempts, so none of these fire across it
	AST_BIT_SFR: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
		s_bit_sfr_req ##0 sfr_bit_capable[{operand[7:3], 3'h0}] |=> ans_space == MAD_SPACE_SFR && !ans_fault
		&& ans_addr == {$past(operand[7:3]), 3'h0} && ans_bit == $past(operand[2:0]))
		else $error("bit-capable special register not reached");
	AST_BIT_REFUSED: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
		s_bit_sfr_req ##0 !sfr_bit_capable[{operand[7:3], 3'h0}] |=> ans_fault && ans_space == MAD_SPACE_NONE)
		else $error("bit access to plain special register not refused");
	AST_EXTENDED_RAM_OPEN: assert property (@(posedge clock) disable iff (!nrst) // RULE_08
		s_extended_ram_req ##0 memory_configuration[1:0] == 2'h1 |=> ans_space == MAD_SPACE_EXTENDED_RAM && !ans_fault
		&& ans_bytes == 2'h1 && ans_cycles == 4'h4)
		else $error("enabled extended RAM not selected");
	AST_XINDIRECT_ADDR: assert property (@(posedge clock) disable iff (!nrst) // RULE_12
		req_valid && req_mode == MAD_MODE_XINDIRECT && !stack_access |=>
		ans_addr == $past(index_register))
		else $error("extended indirect address wrong");
	AST_STACK_ADDR: assert property (@(posedge clock) disable iff (!nrst) // RULE_17
		s_extended_ram_req ##0 stack_access |=> ans_addr == $past(stack_pointer))
		else $error("stack traffic not steered by the stack pointer");
	AST_EXTENDED_RAM_ONLY: assert property (@(posedge clock) disable iff (!nrst) // RULE_06
		ans_valid && ans_space == MAD_SPACE_EXTENDED_RAM |->
		$past(req_mode) inside {MAD_MODE_XDIRECT, MAD_MODE_XINDIRECT})
		else $error("extended RAM reached by a non-extended mode");
	AST_CODE_ONLY: assert property (@(posedge clock) disable iff (!nrst) // RULE_09
		ans_valid && ans_space == MAD_SPACE_CODE |->
		$past(req_mode) inside {MAD_MODE_CODE_DATA_POINTER_PAIR, MAD_MODE_CODE_PC})
		else $error("code space reached by a non-code mode");
	AST_CODE_DATA_POINTER_PAIR: assert property (@(posedge clock) disable iff (!nrst) // RULE_10
		req_valid && req_mode == MAD_MODE_CODE_DATA_POINTER_PAIR |=> ans_space == MAD_SPACE_CODE && ans_cycles == 4'h4
		&& ans_bytes == 2'h1 && ans_code_addr == 14'($past(data_pointer_pair) + {8'h00, $past(accumulator)}))
		else $error("pointer code read wrong");
	AST_JUMP_ADDR: assert property (@(posedge clock) disable iff (!nrst) // RULE_10
		req_valid && req_mode == MAD_MODE_JUMP_DATA_POINTER_PAIR |=> ans_space == MAD_SPACE_NONE && ans_bytes == 2'h1
		&& ans_code_addr == 14'($past(data_pointer_pair) + {8'h00, $past(accumulator)}))
		else $error("indexed jump target wrong");
	AST_IMM_COST: assert property (@(posedge clock) disable iff (!nrst) // RULE_13
		req_valid && req_mode == MAD_MODE_IMM |=>
		ans_bytes == 2'h2 && ans_cycles == 4'h2 && ans_space == MAD_SPACE_NONE)
		else $error("immediate cost wrong");
	AST_ONE_BYTE: assert property (@(posedge clock) disable iff (!nrst) // RULE_16
		req_valid && req_mode inside {MAD_MODE_REG, MAD_MODE_INDIRECT} |=> ans_bytes == 2'h1 && !ans_fault)
		else $error("register or indirect length wrong");
	AST_SHORT_COST: assert property (@(posedge clock) disable iff (!nrst) // RULE_15
		ans_valid && $past(req_mode) inside {MAD_MODE_REG, MAD_MODE_DIRECT, MAD_MODE_INDIRECT,
		MAD_MODE_IMM, MAD_MODE_BIT} |-> ans_cycles inside {4'h1, 4'h2})
		else $error("common mode slower than two cycles");
	AST_FAULT_NOWHERE: assert property (@(posedge clock) disable iff (!nrst) // RULE_08
		ans_fault |-> ans_space == MAD_SPACE_NONE)
		else $error("faulted access still selected a space");
	AST_CFG_HOLD: assert property (@(posedge clock) disable iff (!nrst) // RULE_07
		!sfr_wr |=> $stable(memory_configuration))
		else $error("configuration changed without a write");
	AST_REG_SPACE: assert property (@(posedge clock) disable iff (!nrst) // RULE_13
		req_valid && req_mode == MAD_MODE_REG |=> ans_space == MAD_SPACE_IRAM)
		else $error("register operand left internal RAM");
endmodule // mad_decode

// ==== src/mad_consts.svh ====
/*
 Offsets, field positions, reset values and cycle costs for the memory
 addressing decoder. Assumes inclusion by the decoder only.
*/
`ifndef MAD_CONSTS_SVH
`define MAD_CONSTS_SVH
`define MAD_BIT_RAM_BASE     8'h20
`define MAD_BIT_RAM_LAST     8'h2F
`define MAD_BIT_ADDR_LAST    8'h7F
`define MAD_SFR_BASE         8'h80
`define MAD_MEMCFG_ADDR      8'hAF
`define MAD_MEMCFG_RESET     8'h00
`define MAD_MEMCFG_EN_LSB    0
`define MAD_MEMCFG_EN_MSB    1
`define MAD_MEMCFG_EN_VAL    2'h1
`define MAD_EXTENDED_RAM_LAST        16'h00FF
`define MAD_CODE_ADDR_W      14
`define MAD_CYC_REG          4'h1
`define MAD_CYC_DIRECT       4'h2
`define MAD_CYC_INDIRECT     4'h2
`define MAD_CYC_IMM          4'h2
`define MAD_CYC_IMM_DATA_POINTER_PAIR     4'h3
`define MAD_CYC_XMOVE        4'h4
`define MAD_CYC_CODE_READ    4'h4
`define MAD_CYC_CODE_JUMP    4'h3
`define MAD_LEN_ONE          2'h1
`define MAD_LEN_TWO          2'h2
`define MAD_LEN_THREE        2'h3
`endif

// ==== src/mad_pkg.sv ====
/*
 Types for the memory addressing decoder.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mad_pkg;
	typedef enum logic [3:0] {
		MAD_MODE_REG,
		MAD_MODE_DIRECT,
		MAD_MODE_INDIRECT,
		MAD_MODE_IMM,
		MAD_MODE_IMM_DATA_POINTER_PAIR,
		MAD_MODE_BIT,
		MAD_MODE_XDIRECT,
		MAD_MODE_XINDIRECT,
		MAD_MODE_CODE_DATA_POINTER_PAIR,
		MAD_MODE_CODE_PC,
		MAD_MODE_JUMP_DATA_POINTER_PAIR
	} mad_mode_t;
	typedef enum logic [2:0] {
		MAD_SPACE_NONE,
		MAD_SPACE_IRAM,
		MAD_SPACE_SFR,
		MAD_SPACE_EXTENDED_RAM,
		MAD_SPACE_CODE
	} mad_space_t;
endpackage

// ==== dv/tb.sv ====
/*
 Self-checking bench for the memory addressing decoder: table of mode cases, then config, idle and reset tests.
 Assumes mad_pkg and mad_decode are compiled first; inputs change 2 ns after the rising edge.
*/
`timescale 1ns/1ps
module tb;
	import mad_pkg::*;
	typedef struct {
		mad_mode_t m;
		logic [7:0] op, ix;
		logic sa;
		mad_space_t sp;
		logic [7:0] ad;
		logic [2:0] bt;
		logic [13:0] ca;
		logic [1:0] by;
		logic [3:0] cy;
		logic ft;
		logic [3:0] ck;
	} mad_row_t;
	logic clock, nrst, req_valid, stack_access, sfr_wr, ans_valid, ans_fault;
	mad_mode_t req_mode;
	mad_space_t ans_space;
	logic [7:0] operand, index_register, accumulator, stack_pointer, sfr_wdata, ans_addr, memory_configuration;
	logic [15:0] data_pointer_pair, program_counter;
	logic [255:0] sfr_bit_capable;
	logic [2:0] ans_bit;
	logic [13:0] ans_code_addr;
	logic [1:0] ans_bytes;
	logic [3:0] ans_cycles;
	int errors, check_count, cycles, i;
	mad_row_t rows [18];

	mad_decode DUT (.clock(clock), .nrst(nrst), .req_valid(req_valid), .req_mode(req_mode), .operand(operand),
		.index_register(index_register), .data_pointer_pair(data_pointer_pair), .program_counter(program_counter),
		.accumulator(accumulator), .stack_pointer(stack_pointer), .stack_access(stack_access), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_bit_capable(sfr_bit_capable), .ans_valid(ans_valid), .ans_space(ans_space),
		.ans_addr(ans_addr), .ans_bit(ans_bit), .ans_code_addr(ans_code_addr), .ans_bytes(ans_bytes),
		.ans_cycles(ans_cycles), .ans_fault(ans_fault), .memory_configuration(memory_configuration));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic apply(input mad_row_t r);
		req_valid = 1'b1;
		req_mode = r.m;
		operand = r.op;
		index_register = r.ix;
		stack_access = r.sa;
	endtask

	task automatic check(input mad_row_t r);
		chk(ans_valid, 1'b1);
		chk(ans_bytes, r.by);
		chk(ans_cycles, r.cy);
		chk(ans_fault, r.ft);
		if (r.ck[0]) chk(ans_space, r.sp);
		if (r.ck[1]) chk(ans_addr, r.ad);
		if (r.ck[2]) chk(ans_bit, r.bt);
		if (r.ck[3]) chk(ans_code_addr, r.ca);
	endtask

	// One-shot request with an idle cycle after it, so the answer is isolated
	task automatic single(input mad_row_t r);
		@(posedge clock);
		#2 apply(r);
		@(posedge clock);
		#2 req_valid = 1'b0;
	endtask

	task automatic cfg(input logic [7:0] v);
		@(posedge clock);
		#2 sfr_wr = 1'b1;
		sfr_wdata = v;
		@(posedge clock);
		#2 sfr_wr = 1'b0;
		chk(memory_configuration, v);
	endtask

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Hang guard: the whole sequence needs well under the 2000 cycles at which it fires
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			summarize();
		end
	end

	initial begin
		nrst = 1'b0; req_valid = 1'b0; req_mode = MAD_MODE_REG; operand = 8'h00; index_register = 8'h00;
		stack_access = 1'b0; sfr_wr = 1'b0; sfr_wdata = 8'h00; accumulator = 8'h20; stack_pointer = 8'h40;
		data_pointer_pair = 16'h7FF0; program_counter = 16'h0100; sfr_bit_capable = 256'h0;
		sfr_bit_capable[8'hD0] = 1'b1;
		rows[0] = '{MAD_MODE_REG, 8'h00, 8'h00, 0, MAD_SPACE_IRAM, 8'h00, 3'h0, 14'h0000, 2'h1, 4'h1, 0, 4'h1};
		rows[1] = '{MAD_MODE_DIRECT, 8'h7F, 8'h00, 0, MAD_SPACE_IRAM, 8'h7F, 3'h0, 14'h0000, 2'h2, 4'h2, 0, 4'h3};
		rows[2] = '{MAD_MODE_DIRECT, 8'h80, 8'h00, 0, MAD_SPACE_SFR, 8'h80, 3'h0, 14'h0000, 2'h2, 4'h2, 0, 4'h3};
		rows[3] = '{MAD_MODE_DIRECT, 8'hFF, 8'h00, 0, MAD_SPACE_SFR, 8'hFF, 3'h0, 14'h0000, 2'h2, 4'h2, 0, 4'h3};
		rows[4] = '{MAD_MODE_INDIRECT, 8'h00, 8'h80, 0, MAD_SPACE_IRAM, 8'h80, 3'h0, 14'h0000, 2'h1, 4'h2, 0, 4'h3};
		rows[5] = '{MAD_MODE_INDIRECT, 8'h00, 8'hFF, 0, MAD_SPACE_IRAM, 8'hFF, 3'h0, 14'h0000, 2'h1, 4'h2, 0, 4'h3};
		rows[6] = '{MAD_MODE_IMM, 8'h00, 8'h00, 0, MAD_SPACE_NONE, 8'h00, 3'h0, 14'h0000, 2'h2, 4'h2, 0, 4'h1};
		rows[7] = '{MAD_MODE_IMM_DATA_POINTER_PAIR, 8'h00, 8'h00, 0, MAD_SPACE_NONE, 8'h00, 3'h0, 14'h0000, 2'h3, 4'h3, 0, 4'h1};
		rows[8] = '{MAD_MODE_BIT, 8'h00, 8'h00, 0, MAD_SPACE_IRAM, 8'h20, 3'h0, 14'h0000, 2'h2, 4'h2, 0, 4'h7};
		rows[9] = '{MAD_MODE_BIT, 8'h7F, 8'h00, 0, MAD_SPACE_IRAM, 8'h2F, 3'h7, 14'h0000, 2'h2, 4'h2, 0, 4'h7};
		rows[10] = '{MAD_MODE_BIT, 8'hD3, 8'h00, 0, MAD_SPACE_SFR, 8'hD0, 3'h3, 14'h0000, 2'h2, 4'h2, 0, 4'h7};
		rows[11] = '{MAD_MODE_BIT, 8'h87, 8'h00, 0, MAD_SPACE_NONE, 8'h00, 3'h0, 14'h0000, 2'h2, 4'h2, 1, 4'h1};
		rows[12] = '{MAD_MODE_XDIRECT, 8'h00, 8'h00, 0, MAD_SPACE_EXTENDED_RAM, 8'hF0, 3'h0, 14'h0000, 2'h1, 4'h4, 0, 4'h3};
		rows[13] = '{MAD_MODE_XINDIRECT, 8'h00, 8'h80, 0, MAD_SPACE_EXTENDED_RAM, 8'h80, 3'h0, 14'h0000, 2'h1, 4'h4, 0, 4'h3};
		rows[14] = '{MAD_MODE_XINDIRECT, 8'h00, 8'h80, 1, MAD_SPACE_EXTENDED_RAM, 8'h40, 3'h0, 14'h0000, 2'h1, 4'h4, 0, 4'h3};
		rows[15] = '{MAD_MODE_CODE_DATA_POINTER_PAIR, 8'h00, 8'h00, 0, MAD_SPACE_CODE, 8'h00, 3'h0, 14'h0010, 2'h1, 4'h4, 0, 4'h9};
		rows[16] = '{MAD_MODE_CODE_PC, 8'h00, 8'h00, 0, MAD_SPACE_CODE, 8'h00, 3'h0, 14'h0120, 2'h1, 4'h4, 0, 4'h9};
		rows[17] = '{MAD_MODE_JUMP_DATA_POINTER_PAIR, 8'h00, 8'h00, 0, MAD_SPACE_NONE, 8'h00, 3'h0, 14'h0010, 2'h1, 4'h3, 0, 4'h9};
		repeat (4) @(posedge clock);
		#2 chk(memory_configuration, 8'h00);
		chk(ans_space, MAD_SPACE_NONE);
		nrst = 1'b1;
		cfg(8'h01);
		// Back-to-back: row i is driven in the same slot that row i-1 is checked
		for (i = 0; i <= 18; i++) begin
			@(posedge clock);
			#2;
			if (i > 0) check(rows[i - 1]);
			if (i < 18) apply(rows[i]);
			else req_valid = 1'b0;
		end
		@(posedge clock);
		#2 chk(ans_valid, 1'b0);
		cfg(8'h03);
		single(rows[13]);
		chk(ans_fault, 1'b1);
		chk(ans_space, MAD_SPACE_NONE);
		cfg(8'h05);
		single(rows[12]);
		chk(ans_space, MAD_SPACE_EXTENDED_RAM);
		chk(ans_addr, 8'hF0);
		// Mid-run reset must drop the enable again
		nrst = 1'b0;
		#3 chk(memory_configuration, 8'h00);
		chk(ans_valid, 1'b0);
		@(posedge clock);
		#2 nrst = 1'b1;
		single(rows[13]);
		chk(ans_fault, 1'b1);
		summarize();
	end
endmodule // tb
